// file: hw/cjl_pkg.sv
package cjl_pkg;

  // ********************************
  // flags
  // ********************************
  localparam int NUM_FLAGS = 5;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_S = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_D = 4;
  localparam logic [NUM_FLAGS-1:0] RST_FLAGS = 5'h00;

  // ********************************
  // opcodes
  // ********************************
  localparam logic [7:0] OPC_CMP_R_R = 8'hA2, OPC_CMP_R_IND = 8'hA3, OPC_CMP_BR_BR = 8'hA4;
  localparam logic [7:0] OPC_CMP_BR_BIND = 8'hA5, OPC_CMP_BR_IMM = 8'hA6, OPC_CMP_BIND_IMM = 8'hA7;
  localparam logic [7:0] OPC_XCMP_EXT = 8'hA8, OPC_XCMP_IMM = 8'hA9, OPC_WORD_MOVE = 8'hE8;
  localparam logic [7:0] OPC_JUMP_ALWAYS = 8'h8B;
  localparam logic [3:0] NIB_JUMP = 4'hB, NIB_LOAD_IMM = 4'hC;
  localparam logic [7:0] OPC_LOAD_R_X = 8'hC7, OPC_LOAD_X_R = 8'hD7, OPC_LOAD_R_IND = 8'hE3;
  localparam logic [7:0] OPC_LOAD_BR_BR = 8'hE4, OPC_LOAD_BR_BIND = 8'hE5, OPC_LOAD_BR_IMM = 8'hE6;
  localparam logic [7:0] OPC_LOAD_BIND_IMM = 8'hE7, OPC_LOAD_IND_R = 8'hF3;
  localparam logic [7:0] OPC_LOAD_BIND_BR = 8'hF5;
  localparam logic [7:0] OPC_PMEM_RD = 8'hC2, OPC_PMEM_RD_IND = 8'hC5, OPC_PMEM_WR = 8'hD2;
  localparam logic [7:0] OPC_PMEM_BLK_RD = 8'hC3, OPC_PMEM_BLK_WR = 8'hD3;
  localparam logic [7:0] OPC_DMEM_RD = 8'h82, OPC_DMEM_WR = 8'h92;
  localparam logic [7:0] OPC_DMEM_BLK_RD = 8'h83, OPC_DMEM_BLK_WR = 8'h93;

  // ********************************
  // jump conditions
  // ********************************
  localparam logic [3:0] JC_F = 4'h0, JC_LT = 4'h1, JC_LE = 4'h2, JC_ULE = 4'h3;
  localparam logic [3:0] JC_OV = 4'h4, JC_MI = 4'h5, JC_EQ = 4'h6, JC_ULT = 4'h7;
  localparam logic [3:0] JC_T = 4'h8, JC_GE = 4'h9, JC_GT = 4'hA, JC_UGT = 4'hB;
  localparam logic [3:0] JC_NOV = 4'hC, JC_PL = 4'hD, JC_NE = 4'hE, JC_UGE = 4'hF;

  // ********************************
  // cycle counts and pointer step
  // ********************************
  localparam logic [2:0] FCH_2 = 3'h2, FCH_3 = 3'h3, FCH_4 = 3'h4, FCH_5 = 3'h5;
  localparam logic [3:0] CYC_1 = 4'h1, CYC_2 = 4'h2, CYC_3 = 4'h3, CYC_4 = 4'h4;
  localparam logic [3:0] CYC_5 = 4'h5, CYC_9 = 4'h9;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // ********************************
  // types
  // ********************************
  typedef enum logic [1:0] {st_idle = 2'h1, st_run = 2'h2} cjl_fsm_t;

  typedef enum logic [11:0] {
    no_op = 12'h001, compare_op = 12'h002, compare_with_carry_op = 12'h004,
    ext_compare_with_carry_op = 12'h008, ext_compare_op = 12'h010,
    relative_jump_op = 12'h020, register_load_op = 12'h040, program_mem_load_op = 12'h080,
    program_mem_block_load_op = 12'h100, data_mem_load_op = 12'h200,
    data_mem_block_load_op = 12'h400, ext_word_load_op = 12'h800
  } cjl_class_t;

  typedef enum logic [9:0] {
    mode_none = 10'h001, wreg_mode = 10'h002, reg_mode = 10'h004,
    indirect_working_reg_mode = 10'h008, indirect_reg_mode = 10'h010,
    immediate_mode = 10'h020, extended_register_mode = 10'h040,
    indirect_pair_mode = 10'h080, indexed_mode = 10'h100, direct_target_mode = 10'h200
  } cjl_mode_t;

  typedef enum logic [4:0] {
    fa_func = 5'h01, fa_keep = 5'h02, fa_undef = 5'h04, fa_zero = 5'h08, fa_one = 5'h10
  } cjl_flag_act_t;

  typedef struct packed {
    cjl_class_t cls;
    cjl_mode_t dmode;
    cjl_mode_t smode;
    logic [2:0] fetch;
    logic [3:0] exec;
    cjl_flag_act_t [NUM_FLAGS-1:0] fact;
    logic legal;
  } cjl_dec_t;

  localparam cjl_flag_act_t [NUM_FLAGS-1:0] KEEP_FLAG_ACT = '{default: fa_keep};
  localparam cjl_flag_act_t [NUM_FLAGS-1:0] CMP_FLAG_ACT =
    '{fa_keep, fa_func, fa_func, fa_func, fa_func};

  localparam cjl_dec_t DEC_RST = '{cls: no_op, dmode: mode_none, smode: mode_none,
    fetch: 3'h0, exec: 4'h0, fact: KEEP_FLAG_ACT, legal: 1'b0};

  typedef struct packed {
    cjl_fsm_t fsm;
    logic [3:0] cnt;
    cjl_dec_t dec;
    logic [7:0] opc;
    logic [15:0] dval;
    logic [15:0] sval;
    logic [7:0] disp;
    logic [15:0] pc;
    logic [7:0] preg;
    logic [15:0] pmem;
    logic [7:0] rdat;
    logic rd_wait;
    logic [NUM_FLAGS-1:0] flags;
    logic done;
    logic illegal;
    logic pc_load;
    logic [15:0] pc_out;
    logic wr_en;
    logic wr_word;
    logic [15:0] wr_data;
    logic mem_rd;
    logic mem_wr;
    logic prog;
    logic [15:0] maddr;
    logic [7:0] mwdata;
    logic ptr_upd;
    logic [7:0] preg_out;
    logic [15:0] pmem_out;
  } cjl_state_t;

  localparam cjl_state_t STATE_RST = '{fsm: st_idle, dec: DEC_RST, flags: RST_FLAGS,
    default: '0};

endpackage

// file: hw/cjl_alu_if.sv
`timescale 1ns/100ps
interface cjl_alu_if;
  logic [7:0] dst;
  logic [7:0] src;
  logic cin;
  logic use_carry;
  logic c;
  logic z;
  logic s;
  logic v;
  modport alu (input dst, input src, input cin, input use_carry,
    output c, output z, output s, output v);
  modport user (output dst, output src, output cin, output use_carry,
    input c, input z, input s, input v);
endinterface

// file: hw/cjl_flag_alu.sv
`timescale 1ns/100ps
module cjl_flag_alu (
  cjl_alu_if.alu bus
);
  import cjl_pkg::*;

  // ********************************
  // subtract for flags only
  // ********************************
  logic [8:0] diff;
  logic borrow_in;

  assign borrow_in = bus.cin & bus.use_carry;
  assign diff = {1'b0, bus.dst} - {1'b0, bus.src} - {8'h00, borrow_in};
  assign bus.c = diff[8];
  assign bus.z = (diff[7:0] == 8'h00);
  assign bus.s = diff[7];
  assign bus.v = (bus.dst[7] ^ bus.src[7]) & (bus.dst[7] ^ diff[7]);

endmodule

// file: hw/cjl_decode_exec.sv
`timescale 1ns/100ps
// Function
// RULE_01: opcodes A2 to A7 compare source against destination and set carry, zero, sign, overflow.
// RULE_02: with the extension prefix A2 to A7 compare with borrow, decimal flag kept.
// RULE_03: prefixed A8 and A9 are extended compare with carry, five fetch and three exec cycles.
// RULE_04: A8 and A9 are extended compare, four fetch and three exec cycles, compare flags.
// RULE_05: each flag is taken from the result, kept, left undefined, cleared or set per opcode.
// RULE_06: 8B adds the signed displacement to the program counter, two and two cycles, no flags.
// RULE_07: x B opcodes jump only when the encoded condition holds, two and two cycles, no flags.
// RULE_08: x C loads an immediate into a working register and register loads touch no flag.
// RULE_09: C2 and D2 move program memory in five exec cycles, C5 takes nine.
// RULE_10: C3 and D3 take nine exec cycles and step both pointers by one.
// RULE_11: 82 and 92 move data memory in two fetch and five exec cycles, no flags.
// RULE_12: 83 and 93 take nine exec cycles and step both pointers afterwards.
// RULE_13: prefixed E8 moves a word between extended registers, five fetch, four exec, no flags.
// RULE_14: compares write no operand, only the flags change.
module cjl_decode_exec (
  input wire logic clk,
  input wire logic rstn,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic op_prefix,
  input wire logic [7:0] opcode,
  input wire logic [15:0] dst_val,
  input wire logic [15:0] src_val,
  input wire logic [7:0] disp,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] ptr_reg_in,
  input wire logic [15:0] ptr_mem_in,
  input wire logic [7:0] mem_rdata,
  output cjl_pkg::cjl_class_t op_class,
  output cjl_pkg::cjl_mode_t dst_mode,
  output cjl_pkg::cjl_mode_t src_mode,
  output logic [2:0] fetch_cycles,
  output logic [3:0] exec_cycles,
  output logic illegal,
  output logic done,
  output logic [cjl_pkg::NUM_FLAGS-1:0] flags,
  output logic pc_load,
  output logic [15:0] pc_out,
  output logic wr_en,
  output logic wr_word,
  output logic [15:0] wr_data,
  output logic mem_rd,
  output logic mem_wr,
  output logic prog_space,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic ptr_upd,
  output logic [7:0] ptr_reg_out,
  output logic [15:0] ptr_mem_out
);
  import cjl_pkg::*;

  // ********************************
  // decode
  // ********************************
  function automatic cjl_dec_t mk(input cjl_class_t c, input cjl_mode_t dm, input cjl_mode_t sm,
    input logic [2:0] f, input logic [3:0] e);
    cjl_dec_t d;
    d = DEC_RST;
    d.cls = c;
    d.dmode = dm;
    d.smode = sm;
    d.fetch = f;
    d.exec = e;
    d.legal = 1'b1;
    return d;
  endfunction

  function automatic cjl_dec_t decode_op(input logic pfx, input logic [7:0] op);
    cjl_dec_t d;
    d = DEC_RST;
    if (op >= OPC_CMP_R_R && op <= OPC_XCMP_IMM) begin
      unique case (op)
        OPC_CMP_R_R: d = mk(compare_op, wreg_mode, wreg_mode, FCH_2, CYC_3); // RULE_01
        OPC_CMP_R_IND: d = mk(compare_op, wreg_mode, indirect_working_reg_mode, FCH_2, CYC_3);
        OPC_CMP_BR_BR: d = mk(compare_op, reg_mode, reg_mode, FCH_3, CYC_3);
        OPC_CMP_BR_BIND: d = mk(compare_op, reg_mode, indirect_reg_mode, FCH_3, CYC_3);
        OPC_CMP_BR_IMM: d = mk(compare_op, reg_mode, immediate_mode, FCH_3, CYC_3);
        OPC_CMP_BIND_IMM: d = mk(compare_op, indirect_reg_mode, immediate_mode, FCH_3, CYC_3);
        OPC_XCMP_EXT: d = mk(ext_compare_op, extended_register_mode, extended_register_mode,
          FCH_4, CYC_3); // RULE_04
        OPC_XCMP_IMM: d = mk(ext_compare_op, extended_register_mode, immediate_mode,
          FCH_4, CYC_3); // RULE_04
        default: d = DEC_RST;
      endcase
      d.fact = CMP_FLAG_ACT; // RULE_05
      if (pfx) begin
        d.fetch = d.fetch + {2'b00, pfx}; // RULE_03
        d.cls = (op >= OPC_XCMP_EXT) ? ext_compare_with_carry_op : compare_with_carry_op; // RULE_02
      end
    end else if (pfx) begin
      if (op == OPC_WORD_MOVE) begin
        d = mk(ext_word_load_op, extended_register_mode, extended_register_mode,
          FCH_5, CYC_4); // RULE_13
      end
    end else if (op[3:0] == NIB_JUMP) begin
      d = mk(relative_jump_op, direct_target_mode, mode_none, FCH_2, CYC_2); // RULE_07
    end else if (op[3:0] == NIB_LOAD_IMM) begin
      d = mk(register_load_op, wreg_mode, immediate_mode, FCH_2, CYC_2); // RULE_08
    end else begin
      unique case (op)
        OPC_LOAD_R_X: d = mk(register_load_op, wreg_mode, indexed_mode, FCH_3, CYC_3);
        OPC_LOAD_X_R: d = mk(register_load_op, indexed_mode, wreg_mode, FCH_3, CYC_4);
        OPC_LOAD_R_IND: d = mk(register_load_op, wreg_mode, indirect_working_reg_mode,
          FCH_2, CYC_3);
        OPC_LOAD_BR_BR: d = mk(register_load_op, reg_mode, reg_mode, FCH_3, CYC_2);
        OPC_LOAD_BR_BIND: d = mk(register_load_op, reg_mode, indirect_reg_mode, FCH_3, CYC_4);
        OPC_LOAD_BR_IMM: d = mk(register_load_op, reg_mode, immediate_mode, FCH_3, CYC_2);
        OPC_LOAD_BIND_IMM: d = mk(register_load_op, indirect_reg_mode, immediate_mode,
          FCH_3, CYC_3);
        OPC_LOAD_IND_R: d = mk(register_load_op, indirect_working_reg_mode, wreg_mode,
          FCH_2, CYC_3);
        OPC_LOAD_BIND_BR: d = mk(register_load_op, indirect_reg_mode, reg_mode, FCH_3, CYC_3);
        OPC_PMEM_RD: d = mk(program_mem_load_op, wreg_mode, indirect_pair_mode, FCH_2, CYC_5);
        OPC_PMEM_RD_IND: d = mk(program_mem_load_op, indirect_working_reg_mode,
          indirect_pair_mode, FCH_2, CYC_9); // RULE_09
        OPC_PMEM_WR: d = mk(program_mem_load_op, indirect_pair_mode, wreg_mode, FCH_2, CYC_5);
        OPC_PMEM_BLK_RD: d = mk(program_mem_block_load_op, indirect_working_reg_mode,
          indirect_pair_mode, FCH_2, CYC_9); // RULE_10
        OPC_PMEM_BLK_WR: d = mk(program_mem_block_load_op, indirect_pair_mode,
          indirect_working_reg_mode, FCH_2, CYC_9);
        OPC_DMEM_RD: d = mk(data_mem_load_op, wreg_mode, indirect_pair_mode, FCH_2, CYC_5);
        OPC_DMEM_WR: d = mk(data_mem_load_op, indirect_pair_mode, wreg_mode, FCH_2, CYC_5);
        OPC_DMEM_BLK_RD: d = mk(data_mem_block_load_op, indirect_working_reg_mode,
          indirect_pair_mode, FCH_2, CYC_9); // RULE_12
        OPC_DMEM_BLK_WR: d = mk(data_mem_block_load_op, indirect_pair_mode,
          indirect_working_reg_mode, FCH_2, CYC_9);
        default: d = DEC_RST;
      endcase
    end
    return d;
  endfunction

  function automatic logic cond_true(input logic [3:0] jc, input logic [NUM_FLAGS-1:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    logic r;
    c = f[FLAG_C];
    z = f[FLAG_Z];
    s = f[FLAG_S];
    v = f[FLAG_V];
    unique case (jc)
      JC_F: r = 1'b0;
      JC_LT: r = s ^ v;
      JC_LE: r = z | (s ^ v);
      JC_ULE: r = c | z;
      JC_OV: r = v;
      JC_MI: r = s;
      JC_EQ: r = z;
      JC_ULT: r = c;
      JC_T: r = 1'b1;
      JC_GE: r = ~(s ^ v);
      JC_GT: r = ~(z | (s ^ v));
      JC_UGT: r = ~(c | z);
      JC_NOV: r = ~v;
      JC_PL: r = ~s;
      JC_NE: r = ~z;
      JC_UGE: r = ~c;
    endcase
    return r;
  endfunction

  // ********************************
  // state and flag logic
  // ********************************
  cjl_state_t st_reg;
  cjl_state_t st_next;
  cjl_dec_t cur_dec;
  logic accept;
  logic is_cmp;
  logic is_rd;
  logic is_wr;
  logic [NUM_FLAGS-1:0] flag_func;
  logic [NUM_FLAGS-1:0] flag_new;
  cjl_alu_if alu_bus();

  cjl_flag_alu u_alu (
    .bus(alu_bus.alu)
  );

  assign alu_bus.dst = st_reg.dval[7:0];
  assign alu_bus.src = st_reg.sval[7:0];
  assign alu_bus.cin = st_reg.flags[FLAG_C];
  assign alu_bus.use_carry = (st_reg.dec.cls == compare_with_carry_op) ||
    (st_reg.dec.cls == ext_compare_with_carry_op); // RULE_02
  assign flag_func[FLAG_C] = alu_bus.c;
  assign flag_func[FLAG_Z] = alu_bus.z;
  assign flag_func[FLAG_S] = alu_bus.s;
  assign flag_func[FLAG_V] = alu_bus.v;
  assign flag_func[FLAG_D] = st_reg.flags[FLAG_D];

  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
    assign flag_new[i] = (st_reg.dec.fact[i] == fa_func) ? flag_func[i] :
      (st_reg.dec.fact[i] == fa_zero) ? 1'b0 :
      (st_reg.dec.fact[i] == fa_one) ? 1'b1 : st_reg.flags[i]; // RULE_05
  end

  assign cur_dec = decode_op(op_prefix, opcode);
  assign op_ready = (st_reg.fsm == st_idle);
  assign accept = op_valid && op_ready;
  assign is_cmp = (cur_dec.cls == compare_op) || (cur_dec.cls == compare_with_carry_op) ||
    (cur_dec.cls == ext_compare_op) || (cur_dec.cls == ext_compare_with_carry_op);
  assign is_rd = !op_prefix && ((opcode == OPC_PMEM_RD) || (opcode == OPC_PMEM_RD_IND) ||
    (opcode == OPC_PMEM_BLK_RD) || (opcode == OPC_DMEM_RD) || (opcode == OPC_DMEM_BLK_RD));
  assign is_wr = !op_prefix && ((opcode == OPC_PMEM_WR) || (opcode == OPC_PMEM_BLK_WR) ||
    (opcode == OPC_DMEM_WR) || (opcode == OPC_DMEM_BLK_WR));

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.illegal = 1'b0;
    st_next.pc_load = 1'b0;
    st_next.wr_en = 1'b0;
    st_next.wr_word = 1'b0;
    st_next.mem_rd = 1'b0;
    st_next.mem_wr = 1'b0;
    st_next.ptr_upd = 1'b0;
    st_next.rd_wait = st_reg.mem_rd;
    if (st_reg.rd_wait) begin
      st_next.rdat = mem_rdata;
    end
    unique case (st_reg.fsm)
      st_idle: begin
        if (op_valid) begin
          st_next.dec = cur_dec;
          st_next.opc = opcode;
          st_next.dval = dst_val;
          st_next.sval = src_val;
          st_next.disp = disp;
          st_next.pc = pc_in;
          st_next.preg = ptr_reg_in;
          st_next.pmem = ptr_mem_in;
          if (!cur_dec.legal) begin
            st_next.done = 1'b1;
            st_next.illegal = 1'b1;
          end else begin
            st_next.fsm = st_run;
            st_next.cnt = cur_dec.exec - CYC_1;
            st_next.maddr = ptr_mem_in;
            st_next.prog = (cur_dec.cls == program_mem_load_op) ||
              (cur_dec.cls == program_mem_block_load_op);
            st_next.mem_rd = is_rd; // RULE_09
            st_next.mem_wr = is_wr; // RULE_11
            st_next.mwdata = src_val[7:0];
          end
        end
      end
      st_run: begin
        if (st_reg.cnt != 4'h0) begin
          st_next.cnt = st_reg.cnt - CYC_1;
        end else begin
          st_next.fsm = st_idle;
          st_next.done = 1'b1;
          st_next.flags = flag_new; // RULE_05
          unique case (st_reg.dec.cls)
            relative_jump_op: begin
              st_next.pc_out = st_reg.pc + {{8{st_reg.disp[7]}}, st_reg.disp}; // RULE_06
              st_next.pc_load = cond_true(st_reg.opc[7:4], st_reg.flags); // RULE_07
            end
            register_load_op: begin
              st_next.wr_en = 1'b1; // RULE_08
              st_next.wr_data = st_reg.sval;
            end
            ext_word_load_op: begin
              st_next.wr_en = 1'b1; // RULE_13
              st_next.wr_word = 1'b1;
              st_next.wr_data = st_reg.sval;
            end
            program_mem_load_op, data_mem_load_op,
            program_mem_block_load_op, data_mem_block_load_op: begin
              st_next.wr_en = st_reg.dec.smode == indirect_pair_mode; // RULE_11
              st_next.wr_data = {8'h00, st_reg.rdat};
              if (st_reg.dec.cls == program_mem_block_load_op ||
                  st_reg.dec.cls == data_mem_block_load_op) begin
                st_next.ptr_upd = 1'b1; // RULE_10
                st_next.preg_out = st_reg.preg + PTR_STEP; // RULE_12
                st_next.pmem_out = st_reg.pmem + {8'h00, PTR_STEP}; // RULE_12
              end
            end
            default: st_next.wr_en = 1'b0; // RULE_14
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg <= STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign op_class = st_reg.dec.cls;
  assign dst_mode = st_reg.dec.dmode;
  assign src_mode = st_reg.dec.smode;
  assign fetch_cycles = st_reg.dec.fetch;
  assign exec_cycles = st_reg.dec.exec;
  assign illegal = st_reg.illegal;
  assign done = st_reg.done;
  assign flags = st_reg.flags;
  assign pc_load = st_reg.pc_load;
  assign pc_out = st_reg.pc_out;
  assign wr_en = st_reg.wr_en;
  assign wr_word = st_reg.wr_word;
  assign wr_data = st_reg.wr_data;
  assign mem_rd = st_reg.mem_rd;
  assign mem_wr = st_reg.mem_wr;
  assign prog_space = st_reg.prog;
  assign mem_addr = st_reg.maddr;
  assign mem_wdata = st_reg.mwdata;
  assign ptr_upd = st_reg.ptr_upd;
  assign ptr_reg_out = st_reg.preg_out;
  assign ptr_mem_out = st_reg.pmem_out;

  // ********************************
  // checks
  // ********************************
  cmp_equal_zero_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
    accept && cur_dec.cls == compare_op && dst_val[7:0] == src_val[7:0] |->
    ##4 (done && flags[FLAG_Z] && !flags[FLAG_C]))
    else $error("equal compare did not set zero");
  cpc_borrow_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
    accept && cur_dec.cls == compare_with_carry_op && dst_val[7:0] == src_val[7:0] &&
    flags[FLAG_C] |-> ##4 (done && flags[FLAG_C] && flags[FLAG_S]))
    else $error("compare with carry ignored carry");
  xcpc_timing_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
    accept && op_prefix && (opcode == OPC_XCMP_EXT || opcode == OPC_XCMP_IMM) |->
    ##1 (fetch_cycles == FCH_5 && exec_cycles == CYC_3) ##3 done)
    else $error("extended compare with carry timing wrong");
  xcmp_timing_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
    accept && !op_prefix && (opcode == OPC_XCMP_EXT || opcode == OPC_XCMP_IMM) |->
    ##1 (fetch_cycles == FCH_4 && op_class == ext_compare_op) ##3 done)
    else $error("extended compare timing wrong");
  decimal_kept_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
    accept && is_cmp |-> ##4 (flags[FLAG_D] == $past(flags[FLAG_D], 4)))
    else $error("compare changed decimal flag");
  jump_taken_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
    accept && !op_prefix && opcode == OPC_JUMP_ALWAYS |->
    ##3 (done && pc_load && pc_out == $past(pc_in, 3) + {{8{$past(disp[7], 3)}}, $past(disp, 3)}))
    else $error("unconditional jump target wrong");
  jump_never_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
    accept && !op_prefix && opcode == {JC_F, NIB_JUMP} |-> ##3 (done && !pc_load))
    else $error("never condition jumped");
  load_flags_kept_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
    done && !illegal && st_reg.dec.fact == KEEP_FLAG_ACT |-> flags == $past(flags))
    else $error("flags changed by non-compare");
  pmem_ind_time_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
    accept && !op_prefix && opcode == OPC_PMEM_RD_IND |-> ##1 !done [*8] ##2 (done && wr_en))
    else $error("indirect program load timing wrong");
  pblk_ptr_step_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
    accept && cur_dec.cls == program_mem_block_load_op |->
    ##10 (ptr_upd && ptr_mem_out == $past(ptr_mem_in, 10) + {8'h00, PTR_STEP}))
    else $error("program block pointer not stepped");
  dmem_time_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
    accept && cur_dec.cls == data_mem_load_op |-> ##6 (done && flags == $past(flags, 6)))
    else $error("data load timing wrong");
  dblk_ptr_step_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_12
    accept && cur_dec.cls == data_mem_block_load_op |->
    ##10 (ptr_upd && ptr_reg_out == $past(ptr_reg_in, 10) + PTR_STEP))
    else $error("data block pointer not stepped");
  word_load_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_13
    accept && op_prefix && opcode == OPC_WORD_MOVE |->
    ##1 (fetch_cycles == FCH_5) ##4 (done && wr_en && wr_word && wr_data == $past(src_val, 5)))
    else $error("word load wrong");
  cmp_no_write_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_14
    accept && is_cmp |-> ##1 (!wr_en && !mem_wr) [*4])
    else $error("compare wrote an operand");

endmodule

// file: verif/cjl_mem_model.sv
`timescale 1ns/100ps
module cjl_mem_model (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic prog_space,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata
);
  logic hold_reg = 1'b0;
  logic [7:0] junk_reg = 8'h00;
  // data valid in the read cycle and the next, churning otherwise
  always_ff @(posedge clk) begin
    hold_reg <= mem_rd;
    junk_reg <= ~junk_reg + 8'h3B;
  end
  assign mem_rdata = (mem_rd | hold_reg) ?
    (mem_addr[7:0] ^ (prog_space ? 8'h5A : 8'hA5)) : junk_reg;
endmodule

// file: verif/cpu_compare_jump_load_decode_bench.sv
`timescale 1ns/100ps
module cpu_compare_jump_load_decode_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic op_valid = 1'b0;
  logic op_prefix = 1'b0;
  logic [7:0] opcode = 8'h00, disp = 8'h00, ptr_reg_in = 8'h20;
  logic [15:0] dst_val = 16'h0000, src_val = 16'h0000;
  logic [15:0] pc_in = 16'h1000, ptr_mem_in = 16'h1234;
  logic op_ready, done, pc_load, wr_en, wr_word, mem_rd, mem_wr, prog_space, ptr_upd;
  logic [2:0] fetch_cycles;
  logic illegal;
  logic [3:0] exec_cycles;
  logic [9:0] dst_mode, src_mode;
  logic [11:0] op_class;
  logic [4:0] flags, seen;
  logic [7:0] mem_rdata, mem_wdata, ptr_reg_out;
  logic [15:0] pc_out, wr_data, mem_addr, ptr_mem_out;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  cjl_decode_exec i_dut (.*);
  cjl_mem_model i_mem (.*);
  always #25 clk = ~clk;
  // ********************************
  // shared tasks
  // ********************************
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // offer one opcode, count cycles to done, gather pulses seen
  task automatic run(input logic p, input logic [7:0] o, input logic [15:0] s,
    input logic [7:0] dp, input int lat);
    int n;
    n = 0;
    seen = 5'h00;
    @(negedge clk);
    op_prefix = p;
    opcode = o;
    src_val = s;
    disp = dp;
    op_valid = 1'b1;
    chk(op_ready, 1'b1);
    @(posedge clk);
    do begin
      @(negedge clk);
      op_valid = 1'b0;
      n++;
      seen |= {pc_load, ptr_upd, mem_wr, mem_rd, wr_en};
    end while (done !== 1'b1 && n < 20);
    chk(16'(n), 16'(lat));
  endtask
  task automatic cmp(input logic p, input logic [7:0] o, input logic [15:0] d, s,
    input logic [4:0] f, input logic [2:0] fc);
    dst_val = d;
    run(p, o, s, 8'h00, 4);
    chk(flags, f);
    chk(fetch_cycles, fc);
    chk(exec_cycles, 4'h3);
    chk(seen[2:0], 3'h0);
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_cmp();
    cmp(1'b0, 8'hA2, 16'h0005, 16'h0007, 5'h05, 3'h2);
    cmp(1'b1, 8'hA3, 16'h0006, 16'h0006, 5'h05, 3'h3);
    cmp(1'b1, 8'hA2, 16'h0008, 16'h0006, 5'h00, 3'h3);
    cmp(1'b0, 8'hA8, 16'h0080, 16'h0001, 5'h08, 3'h4);
    cmp(1'b1, 8'hA9, 16'h0010, 16'h0010, 5'h02, 3'h5);
    cmp(1'b0, 8'hA6, 16'h0033, 16'h0033, 5'h02, 3'h3);
  endtask
  task automatic t_jmp();
    run(1'b0, 8'h6B, 16'h0000, 8'hFE, 3);
    chk({seen[4], pc_out}, 17'h10FFE);
    run(1'b0, 8'hEB, 16'h0000, 8'h10, 3);
    chk(seen[4], 1'b0);
    run(1'b0, 8'h0B, 16'h0000, 8'h10, 3);
    chk(seen[4], 1'b0);
    run(1'b0, 8'h8B, 16'h0000, 8'h7F, 3);
    chk({seen[4], pc_out}, 17'h1107F);
    chk({op_class, dst_mode, src_mode}, 32'h02080001);
    chk(flags, 5'h02);
  endtask
  task automatic t_ld();
    run(1'b0, 8'h0C, 16'h003C, 8'h00, 3);
    chk(wr_data, 16'h003C);
    run(1'b0, 8'hE4, 16'h0055, 8'h00, 3);
    chk({seen[0], flags}, 6'h22);
    run(1'b1, 8'hE8, 16'hBEEF, 8'h00, 5);
    chk({wr_word, wr_data, flags}, 22'h37DDE2);
    chk({op_class, dst_mode, src_mode}, 32'h80010040);
    run(1'b1, 8'h00, 16'h0000, 8'h00, 1);
    chk({seen, illegal}, 6'h01);
  endtask
  task automatic t_mem();
    run(1'b0, 8'hC2, 16'h0000, 8'h00, 6);
    chk({seen[1:0], wr_data}, 18'h3006E);
    run(1'b0, 8'hC5, 16'h0000, 8'h00, 10);
    chk({exec_cycles, dst_mode, src_mode}, 24'h902080);
    run(1'b0, 8'hD2, 16'h00A7, 8'h00, 6);
    chk({seen[2:0], mem_wdata}, 11'h4A7);
    run(1'b0, 8'h82, 16'h0000, 8'h00, 6);
    chk(wr_data, 16'h0091);
    run(1'b0, 8'h92, 16'h0033, 8'h00, 6);
    chk({seen[2:0], mem_wdata}, 11'h433);
    run(1'b0, 8'hC3, 16'h0000, 8'h00, 10);
    chk({seen[3], ptr_reg_out, ptr_mem_out}, 25'h1211235);
    run(1'b0, 8'hD3, 16'h0000, 8'h00, 10);
    run(1'b0, 8'h83, 16'h0000, 8'h00, 10);
    chk({seen[3], ptr_reg_out, wr_data}, 25'h1210091);
    run(1'b0, 8'h93, 16'h0000, 8'h00, 10);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    t_cmp();
    t_jmp();
    t_ld();
    t_mem();
    close_out();
  end
endmodule
